// ===== verilog/amp_seq.sv
// amplifier output-mode, input-mux and gain-fade sequencer with AXI4-Lite registers
// assumes control pins are static levels from outside the clock domain
// Operation
// - select low keeps both minus amplifiers on while the plus amplifiers are on
// - select high turns minus amplifiers off
// - source high routes headphone inputs
// - source low routes line inputs
// - source and output mode act independently
// - run low mutes, low current; source select still routes
// - ramp mode picks fade-on or fade-off
// - fade-on shutdown steps down every two ticks
// - fade-on bypass discharge only after lowest step
// - fade-on release: charge bypass, then ramp gain up
// - fade-off shutdown saves gain, mutes at once
// - fade-off release restores saved gain at once
// - power-up ramps from lowest step always
// - single-ended target is volume minus offset, capped
// - zero offset gives 6 dB below bridged
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module amp_seq #(
  parameter int TICK_CYCLES = amp_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // control pins
  input wire logic run,
  input wire logic ramp_mode,
  input wire logic output_config_select,
  input wire logic input_source_select,
  input wire logic bypass_charged,
  input wire logic [amp_pkg::LVL_W-1:0] volume_level,
  input wire logic [amp_pkg::LVL_W-1:0] headphone_offset_level,
  input wire logic [amp_pkg::LVL_W-1:0] headphone_ceiling_level,
  // amplifier controls
  output logic left_minus_output_en,
  output logic right_minus_output_en,
  output logic plus_output_en,
  output logic route_phone_input,
  output logic mute,
  output logic low_current,
  output logic bypass_discharge,
  output logic [amp_pkg::GAIN_W-1:0] gain_step,
  // axi4-lite slave
  input wire logic [amp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [amp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser; level codes are static, so a torn multi-bit sample
  // only lasts one cycle, though the ST_ACTIVE follower copies it to gain_step for that cycle
  logic [amp_pkg::SY_W-1:0] sync1_reg;
  logic [amp_pkg::SY_W-1:0] sync2_reg;
  logic run_s, fade_s, se_s, src_s, byp_s;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {headphone_ceiling_level, headphone_offset_level, volume_level,
                    bypass_charged, input_source_select, output_config_select,
                    ramp_mode, run};
      sync2_reg <= sync1_reg;
    end
  end

  assign run_s = sync2_reg[amp_pkg::SY_RUN];
  assign fade_s = sync2_reg[amp_pkg::SY_FADE];
  assign se_s = sync2_reg[amp_pkg::SY_SE];
  assign src_s = sync2_reg[amp_pkg::SY_SRC];
  assign byp_s = sync2_reg[amp_pkg::SY_BYP];

  amp_gain_if gi ();
  assign gi.volume = sync2_reg[amp_pkg::SY_VOL +: amp_pkg::LVL_W];
  assign gi.offset = sync2_reg[amp_pkg::SY_OFF +: amp_pkg::LVL_W];
  assign gi.ceiling = sync2_reg[amp_pkg::SY_CEIL +: amp_pkg::LVL_W];
  assign gi.se_mode = se_s;

  amp_gain_calc u_calc (
    .gi(gi.calc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // slow step tick; divider is software-writable so a bench can speed it up
  logic [amp_pkg::TICK_W-1:0] tick_div_reg, tick_div_next;
  logic [amp_pkg::TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if ({1'b0, tick_cnt_reg} + 21'h0_0001 >= {1'b0, tick_div_reg}) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fade sequencer
  amp_pkg::amp_state_t state_reg, state_next;
  logic [amp_pkg::GAIN_W-1:0] gain_reg, gain_next, saved_reg, saved_next;
  logic phase_reg, phase_next, pwrup_reg, pwrup_next;
  logic step_ev, act_next;

  assign step_ev = tick_reg && (phase_reg == 1'(amp_pkg::STEP_TICKS - 1));

  always_comb begin
    state_next = state_reg;
    gain_next = gain_reg;
    saved_next = saved_reg;
    pwrup_next = pwrup_reg;
    case (state_reg)
      amp_pkg::ST_OFF: begin
        if (run_s) begin
          state_next = amp_pkg::ST_CHARGE;
        end
      end
      amp_pkg::ST_CHARGE: begin
        gain_next = gi.floor_step;
        if (!run_s) begin
          state_next = amp_pkg::ST_OFF;
        end else if (byp_s) begin
          pwrup_next = 1'b0;
          if (pwrup_reg || !fade_s) begin
            state_next = amp_pkg::ST_RAMP;
          end else begin
            gain_next = saved_reg;
            state_next = amp_pkg::ST_ACTIVE;
          end
        end
      end
      amp_pkg::ST_RAMP, amp_pkg::ST_ACTIVE: begin
        if (!run_s) begin
          saved_next = gain_reg;
          // fade-off drops to midrail at once; fade-on walks down first
          if (fade_s) begin
            state_next = amp_pkg::ST_OFF;
          end else begin
            state_next = amp_pkg::ST_DOWN;
          end
        end else if (state_reg == amp_pkg::ST_ACTIVE) begin
          gain_next = gi.target;
        end else if (gain_reg == gi.target) begin
          state_next = amp_pkg::ST_ACTIVE;
        end else if (step_ev) begin
          if (gain_reg < gi.target) begin
            gain_next = gain_reg + 1'b1;
          end else begin
            gain_next = gain_reg - 1'b1;
          end
        end
      end
      amp_pkg::ST_DOWN: begin
        if (run_s) begin
          state_next = amp_pkg::ST_RAMP;
        end else if (gain_reg <= gi.floor_step) begin
          gain_next = gi.floor_step;
          state_next = amp_pkg::ST_OFF;
        end else if (step_ev) begin
          gain_next = gain_reg - 1'b1;
        end
      end
      default: begin
        state_next = amp_pkg::ST_OFF;
      end
    endcase
    // the step phase restarts with every state change so the first step falls on the second tick
    if (state_next != state_reg) begin
      phase_next = 1'b0;
    end else if (tick_reg) begin
      phase_next = ~phase_reg;
    end else begin
      phase_next = phase_reg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= amp_pkg::ST_CHARGE;
      gain_reg <= amp_pkg::GAIN_RST;
      saved_reg <= amp_pkg::GAIN_RST;
      phase_reg <= 1'b0;
      pwrup_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      gain_reg <= gain_next;
      saved_reg <= saved_next;
      phase_reg <= phase_next;
      pwrup_reg <= pwrup_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // amplifier control outputs, registered from the next state
  assign act_next = (state_next == amp_pkg::ST_RAMP) || (state_next == amp_pkg::ST_ACTIVE) ||
                    (state_next == amp_pkg::ST_DOWN);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      left_minus_output_en <= 1'b0;
      right_minus_output_en <= 1'b0;
      plus_output_en <= 1'b0;
      route_phone_input <= 1'b0;
      mute <= 1'b1;
      low_current <= 1'b0;
      bypass_discharge <= 1'b0;
      gain_step <= amp_pkg::GAIN_RST;
    end else begin
      left_minus_output_en <= act_next && !se_s;
      right_minus_output_en <= act_next && !se_s;
      plus_output_en <= act_next;
      route_phone_input <= src_s;
      mute <= !act_next;
      low_current <= state_next == amp_pkg::ST_OFF;
      bypass_discharge <= state_next == amp_pkg::ST_OFF;
      gain_step <= gain_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [amp_pkg::ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, wr_word;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    tick_div_next = tick_div_reg;
    wr_word = {12'h000, tick_div_reg};
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // commit only once both halves are held, one cycle after the later one
    if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = amp_pkg::RESP_SLVERR;
      if (awaddr_reg[3:2] == amp_pkg::IDX_TICK_DIV) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            wr_word[8*b +: 8] = wdata_reg[8*b +: 8];
          end
        end
        tick_div_next = wr_word[amp_pkg::TICK_W-1:0];
        bresp_next = amp_pkg::RESP_OKAY;
      end
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next = !w_full_next && !bvalid_next;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = amp_pkg::RESP_OKAY;
      rdata_next = '0;
      case (s_axi_araddr[3:2])
        amp_pkg::IDX_TICK_DIV: rdata_next[amp_pkg::TICK_W-1:0] = tick_div_reg;
        amp_pkg::IDX_STATUS: begin
          rdata_next[amp_pkg::ST_GAIN_LSB +: amp_pkg::GAIN_W] = gain_reg;
          rdata_next[amp_pkg::ST_STATE_LSB +: 3] = state_reg;
          rdata_next[amp_pkg::ST_PWRUP_BIT] = pwrup_reg;
          rdata_next[amp_pkg::ST_SAVED_LSB +: amp_pkg::GAIN_W] = saved_reg;
        end
        amp_pkg::IDX_TARGET: begin
          rdata_next[amp_pkg::GAIN_W-1:0] = gi.target;
          rdata_next[amp_pkg::TG_FLOOR_LSB +: amp_pkg::GAIN_W] = gi.floor_step;
        end
        default: rresp_next = amp_pkg::RESP_SLVERR;
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      tick_div_reg <= amp_pkg::TICK_W'(TICK_CYCLES);
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= amp_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= amp_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      tick_div_reg <= tick_div_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_bridged_minus_on: assert property (
    $past(act_next && !se_s) |-> left_minus_output_en && right_minus_output_en)
    else $error("minus amplifiers off in bridged mode");
  a_single_minus_off: assert property (
    $past(se_s) |-> !left_minus_output_en && !right_minus_output_en)
    else $error("minus amplifiers on in single-ended mode");
  a_route_phone: assert property (
    $past(src_s) |-> route_phone_input)
    else $error("headphone inputs not routed");
  a_route_aux: assert property (
    !$past(src_s) |-> !route_phone_input)
    else $error("line inputs not routed");
  a_shutdown_mute: assert property (
    state_reg == amp_pkg::ST_OFF |-> mute && low_current && !plus_output_en)
    else $error("outputs live in shutdown");
  a_down_step_rate: assert property (
    ($past(state_reg) == amp_pkg::ST_DOWN && state_reg == amp_pkg::ST_DOWN &&
     gain_reg != $past(gain_reg)) |-> $past(step_ev) && (gain_reg == $past(gain_reg) - 6'h01))
    else $error("ramp-down step off rate");
  a_discharge_floor: assert property (
    ($past(state_reg) == amp_pkg::ST_DOWN && state_reg == amp_pkg::ST_OFF) |->
    $past(gain_reg) <= $past(gi.floor_step))
    else $error("discharge before lowest step");
  a_charge_first: assert property (
    ($past(state_reg) == amp_pkg::ST_CHARGE && state_reg != amp_pkg::ST_CHARGE &&
     state_reg != amp_pkg::ST_OFF) |-> $past(byp_s))
    else $error("gain raised before bypass charged");
  a_fadeoff_save: assert property (
    ((state_reg == amp_pkg::ST_ACTIVE || state_reg == amp_pkg::ST_RAMP) && !run_s && fade_s)
    |=> state_reg == amp_pkg::ST_OFF && saved_reg == $past(gain_reg))
    else $error("fade-off shutdown did not save and mute");
  a_fadeoff_restore: assert property (
    ($past(state_reg) == amp_pkg::ST_CHARGE && state_reg == amp_pkg::ST_ACTIVE) |->
    gain_reg == saved_reg)
    else $error("saved gain not restored");
  a_powerup_ramp: assert property (
    (pwrup_reg && state_reg == amp_pkg::ST_CHARGE && run_s && byp_s) |=>
    state_reg == amp_pkg::ST_RAMP && !pwrup_reg)
    else $error("power-up skipped the ramp");
  a_se_ceiling: assert property (
    gi.se_mode |-> gi.target <= {1'b0, gi.ceiling})
    else $error("single-ended gain above ceiling");
  a_btl_six_db: assert property (
    (gi.se_mode && gi.offset == 5'h00 && gi.volume <= gi.ceiling) |->
    gi.target + amp_pkg::BTL_OFFSET == {1'b0, gi.volume} + amp_pkg::BTL_OFFSET)
    else $error("single-ended not 6 dB below bridged");
  a_abort_down: assert property (
    (state_reg == amp_pkg::ST_DOWN && run_s) |=> state_reg == amp_pkg::ST_RAMP)
    else $error("release during ramp-down ignored");
  a_follow_target: assert property (
    ($past(state_reg) == amp_pkg::ST_ACTIVE && state_reg == amp_pkg::ST_ACTIVE) |->
    gain_reg == $past(gi.target))
    else $error("active gain not following target");
endmodule

// ===== shared/amp_pkg.sv
// constants and types for the amplifier mode and gain-fade sequencer
// assumes one 20 MHz core clock; gain steps are 2 dB indices on one ladder
package amp_pkg;
  localparam int CLK_HZ = 20_000_000;
  // nominal slow internal clock that paces the fade steps
  localparam int INT_CLK_HZ = 58;
  localparam int TICK_CYCLES = CLK_HZ / INT_CLK_HZ;
  localparam int TICK_W = 20;
  // internal clock ticks per gain step
  localparam int STEP_TICKS = 2;
  localparam int LVL_W = 5;
  localparam int GAIN_W = 6;
  // ladder index 0 is -46 dB; bridged level i sits 3 steps (6 dB) above single-ended level i
  localparam logic [5:0] BTL_OFFSET = 6'h03;
  localparam logic [5:0] SE_FLOOR = 6'h00;
  localparam logic [5:0] BTL_FLOOR = 6'h03;
  localparam logic [5:0] GAIN_RST = 6'h00;
  // register word indices (address bits 3:2) on the AXI4-Lite port
  localparam int ADDR_W = 4;
  localparam logic [1:0] IDX_TICK_DIV = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;
  localparam logic [1:0] IDX_TARGET = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status and target field positions
  localparam int ST_GAIN_LSB = 0;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_PWRUP_BIT = 12;
  localparam int ST_SAVED_LSB = 16;
  localparam int TG_FLOOR_LSB = 8;
  // synchroniser vector layout
  localparam int SY_RUN = 0;
  localparam int SY_FADE = 1;
  localparam int SY_SE = 2;
  localparam int SY_SRC = 3;
  localparam int SY_BYP = 4;
  localparam int SY_VOL = 5;
  localparam int SY_OFF = 10;
  localparam int SY_CEIL = 15;
  localparam int SY_W = 20;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_CHARGE = 3'b001,
    ST_RAMP = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_DOWN = 3'b100
  } amp_state_t;
endpackage

// ===== shared/amp_gain_if.sv
// carrier between the sequencer and its target-gain calculator
// assumes all signals are already in the core clock domain
`timescale 1ns/1ps
interface amp_gain_if;
  logic [amp_pkg::LVL_W-1:0] volume;
  logic [amp_pkg::LVL_W-1:0] offset;
  logic [amp_pkg::LVL_W-1:0] ceiling;
  logic se_mode;
  logic [amp_pkg::GAIN_W-1:0] target;
  logic [amp_pkg::GAIN_W-1:0] floor_step;
  modport calc (input volume, offset, ceiling, se_mode, output target, floor_step);
  modport seq (output volume, offset, ceiling, se_mode, input target, floor_step);
endinterface

// ===== verilog/amp_gain_calc.sv
// target and floor gain step from the volume, offset and ceiling levels
// assumes synchronised level codes; purely combinational
`timescale 1ns/1ps
module amp_gain_calc (
  amp_gain_if.calc gi
);
  logic [amp_pkg::LVL_W-1:0] se_lvl;

  always_comb begin
    // single-ended level is volume minus offset, never below zero, capped by ceiling
    if (gi.offset > gi.volume) begin
      se_lvl = '0;
    end else begin
      se_lvl = gi.volume - gi.offset;
    end
    if (se_lvl > gi.ceiling) begin
      se_lvl = gi.ceiling;
    end
    if (gi.se_mode) begin
      gi.target = {1'b0, se_lvl};
      gi.floor_step = amp_pkg::SE_FLOOR;
    end else begin
      // same level sits 6 dB higher when bridged
      gi.target = {1'b0, gi.volume} + amp_pkg::BTL_OFFSET;
      gi.floor_step = amp_pkg::BTL_FLOOR;
    end
  end
endmodule

// ===== tb/amp_bypass_model.sv
// bench model of the midrail bypass node beside the sequencer
// assumes run is the raw pin level and bypass_discharge comes from the design
`timescale 1ns/1ps
module amp_bypass_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // node control
  input wire logic run,
  input wire logic slow,
  input wire logic bypass_discharge,
  output logic bypass_charged
);
  logic [5:0] charge_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // a count stands in for the capacitor; slow mode stretches the charge time
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_cnt <= 6'h00;
    end else if (bypass_discharge) begin
      charge_cnt <= 6'h00;
    end else if (run && charge_cnt != 6'h3f) begin
      charge_cnt <= charge_cnt + 6'h01;
    end
  end
  // the flag is always driven to a level
  assign bypass_charged = charge_cnt >= (slow ? 6'h28 : 6'h04);
endmodule

// ===== tb/test_amp_mode_and_gain_fade_sequencer.sv
// self-checking bench for the mode, mux and gain-fade sequencer
// assumes a short slow tick so that whole fades fit in a brief run
`timescale 1ns/1ps
module test_amp_mode_and_gain_fade_sequencer;
  localparam int TICK = 4;
  localparam int STEP = amp_pkg::STEP_TICKS * TICK;
  logic core_clk, arst_n, run, ramp_mode, output_config_select, input_source_select;
  logic bypass_charged, slow, mute, low_current, bypass_discharge, plus_output_en;
  logic left_minus_output_en, right_minus_output_en, route_phone_input;
  logic [4:0] volume_level, headphone_offset_level, headphone_ceiling_level;
  logic [5:0] gain_step;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int fail_count, tests_run, cycle_count, n;

  amp_seq #(.TICK_CYCLES(TICK + 1)) amp_seq_inst (.core_clk, .arst_n, .run, .ramp_mode,
    .output_config_select, .input_source_select, .bypass_charged, .volume_level,
    .headphone_offset_level, .headphone_ceiling_level, .left_minus_output_en,
    .right_minus_output_en, .plus_output_en, .route_phone_input, .mute, .low_current,
    .bypass_discharge, .gain_step, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  amp_bypass_model amp_bypass_model_inst (.core_clk, .arst_n, .run, .slow,
    .bypass_discharge, .bypass_charged);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // address and data offered together, each dropped on its own ready
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // follows the gain one step at a time; the first gap is left out since the phase restarts
  task automatic ramp_check(input logic [5:0] to_gain);
    logic [5:0] prev;
    int k;
    bit first;
    prev = gain_step;
    first = 1;
    while (prev != to_gain) begin
      k = 0;
      while (gain_step === prev && k < 4 * STEP) begin
        @(posedge core_clk);
        k++;
      end
      check("gain step", gain_step, to_gain > prev ? prev + 1 : prev - 1);
      if (!first) check("step spacing", k, STEP);
      if (gain_step !== to_gain) check("early discharge", bypass_discharge, 1'h0);
      first = 0;
      prev = gain_step;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  // a hang ends the run as a mismatch
  always @(posedge core_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    {arst_n, run, ramp_mode, output_config_select, input_source_select, slow} = 6'h08;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0000_0000, 4'hf};
    {volume_level, headphone_offset_level, headphone_ceiling_level} = {5'h0a, 5'h00, 5'h1f};
    {fail_count, tests_run, cycle_count} = 0;
    cycles(8);
    arst_n <= 1'h1;
    check("reset mute", mute, 1'h1);
    check("reset gain", gain_step, 6'h00);
    cycles(2);
    axi_read(4'h0, rd, rsp);
    check("tick div", rd, TICK + 1);
    axi_write(4'h0, 32'hfff0_0004, rsp);
    check("write resp", rsp, amp_pkg::RESP_OKAY);
    axi_read(4'h0, rd, rsp);
    check("tick mask", rd, TICK);
    // partial strobes keep the unselected bytes of the divider
    s_axi_wstrb <= 4'he;
    axi_write(4'h0, 32'h00ff_ff00, rsp);
    axi_read(4'h0, rd, rsp);
    check("tick strobe", rd, 32'h000f_ff04);
    s_axi_wstrb <= 4'h6;
    axi_write(4'h0, 32'h0000_0000, rsp);
    axi_read(4'h0, rd, rsp);
    check("tick restore", rd, TICK);
    axi_write(4'h4, 32'h0000_00ff, rsp);
    check("ro resp", rsp, amp_pkg::RESP_SLVERR);
    axi_read(4'hc, rd, rsp);
    check("unmapped data", rd, 32'h0000_0000);
    check("unmapped resp", rsp, amp_pkg::RESP_SLVERR);
    // power-up with fade-off selected still ramps from the floor
    run <= 1'h1;
    wait (bypass_charged === 1'h1);
    cycles(1);
    check("power-up start", gain_step, amp_pkg::BTL_FLOOR);
    ramp_check(6'h0d);
    cycles(2);
    axi_read(4'h8, rd, rsp);
    check("target reg", rd[13:0], 14'h030d);
    for (int i = 0; i < 4; i++) begin
      output_config_select <= i[0];
      input_source_select <= i[1];
      cycles(5);
      check("minus left", left_minus_output_en, !i[0]);
      check("minus right", right_minus_output_en, !i[0]);
      check("plus", plus_output_en, 1'h1);
      check("route", route_phone_input, i[1]);
    end
    check("se gain", gain_step, 6'h0a);
    headphone_offset_level <= 5'h04;
    cycles(5);
    check("se offset", gain_step, 6'h06);
    headphone_ceiling_level <= 5'h03;
    cycles(5);
    check("se ceiling", gain_step, 6'h03);
    {output_config_select, input_source_select} <= 2'h0;
    {volume_level, headphone_offset_level, headphone_ceiling_level} <= {5'h0c, 5'h00, 5'h1f};
    cycles(5);
    check("follow", gain_step, 6'h0f);
    volume_level <= 5'h0a;
    cycles(5);
    // fade-off: mute at once, keep the gain, restore it without steps
    run <= 1'h0;
    cycles(5);
    check("off mute", mute, 1'h1);
    check("off discharge", bypass_discharge, 1'h1);
    check("off minus", left_minus_output_en, 1'h0);
    check("off current", low_current, 1'h1);
    axi_read(4'h4, rd, rsp);
    check("saved gain", rd[21:16], 6'h0d);
    slow <= 1'h1;
    run <= 1'h1;
    wait (bypass_charged === 1'h1);
    for (n = 0; mute === 1'h1 && n < 50; n++) cycles(1);
    check("restore gain", gain_step, 6'h0d);
    check("restore fast", n < STEP, 1'h1);
    slow <= 1'h0;
    ramp_mode <= 1'h0;
    cycles(4);
    // fade-on: step down, turn back midway, then fade to the floor
    run <= 1'h0;
    ramp_check(6'h0a);
    run <= 1'h1;
    ramp_check(6'h0d);
    run <= 1'h0;
    ramp_check(amp_pkg::BTL_FLOOR);
    wait (bypass_discharge === 1'h1);
    cycles(1);
    check("floor at discharge", gain_step, amp_pkg::BTL_FLOOR);
    check("down mute", mute, 1'h1);
    run <= 1'h1;
    wait (bypass_charged === 1'h1);
    check("charged floor", gain_step, amp_pkg::BTL_FLOOR);
    ramp_check(6'h0d);
    give_verdict();
  end
endmodule
